/* File: fah_params.svh */
// register numbers, reset values and timing counts for the file adapter host port
// assumes a 20 MHz system clock; included by the package and by the design modules
`ifndef FAH_PARAMS_SVH
`define FAH_PARAMS_SVH

// extended register numbers answered by the adapter
`define FAH_REG_LOW          5'h10
`define FAH_REG_HIGH         5'h1F
`define FAH_REG_DRIVE_SEL    5'h10
`define FAH_REG_COMMAND      5'h11
`define FAH_REG_HW_STATUS    5'h12
`define FAH_REG_ATTN_STATUS  5'h13
`define FAH_REG_WRITE_DATA   5'h14
`define FAH_REG_CMD_SECOND   5'h15
`define FAH_REG_CYL_STATUS   5'h17

// reset values
`define FAH_DRIVE_DEFAULT    16'h0000
`define FAH_WORD_ZERO        16'h0000
`define FAH_DBC_PRESET       16'hFA08

// timing, figures in ns and derived cycle counts
`define FAH_CLK_NS           50
`define FAH_END_DELAY_NS     1000
`define FAH_END_WIDTH_NS     3000
`define FAH_END_DELAY_CYC    ((`FAH_END_DELAY_NS + `FAH_CLK_NS - 1) / `FAH_CLK_NS)
`define FAH_END_WIDTH_CYC    ((`FAH_END_WIDTH_NS + `FAH_CLK_NS - 1) / `FAH_CLK_NS)

`endif

/* File: fah_pkg.sv */
// types shared by the file adapter host port modules
// assumes fah_params.svh is on the include path
`include "fah_params.svh"

package fah_pkg;

  // read/write control, one-hot
  typedef enum logic [2:0]
  {
    FAH_RW_IDLE   = 3'b001,
    FAH_RW_SECOND = 3'b010,
    FAH_RW_ACTIVE = 3'b100
  } fah_rw_state_t;

  // control-store load control, one-hot
  typedef enum logic [2:0]
  {
    FAH_LD_IDLE = 3'b001,
    FAH_LD_RUN  = 3'b010,
    FAH_LD_END  = 3'b100
  } fah_ld_state_t;

  // status words offered by the drive side
  typedef struct packed
  {
    logic [15:0] hw_status;
    logic [15:0] attn_status;
    logic [15:0] cyl_status;
    logic [15:0] read_data;
  } fah_status_t;

  // command held for the drive side
  typedef struct packed
  {
    logic [15:0] first;
    logic [15:0] second;
  } fah_cmd_t;

endpackage

/* File: fah_end_timer.sv */
// end-out pulse former: waits a delay after the trigger, then holds high
// for at least the width and until the release input falls
`timescale 1ns/1ns
`include "fah_params.svh"

module fah_end_timer
  import fah_pkg::*;
#(
  parameter int DELAY_CYC = `FAH_END_DELAY_CYC,
  parameter int WIDTH_CYC = `FAH_END_WIDTH_CYC
)
(
  input  wire logic i_clk_sys,  // system clock
  input  wire logic i_reset,    // sync reset, active high
  input  wire logic i_clear,    // master clear, drops the pulse
  input  wire logic i_trigger,  // one-cycle start pulse
  input  wire logic i_hold,     // keeps the pulse up after the width
  output logic      o_pulse     // registered end pulse
);

  logic [7:0] count;
  logic       waiting;

  // one counter serves both the delay and the width
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || i_clear)
    begin
      count   <= 8'h00;
      waiting <= 1'b0;
      o_pulse <= 1'b0;
    end
    else if (i_trigger && !waiting && !o_pulse)
    begin
      waiting <= 1'b1;
      count   <= 8'(DELAY_CYC - 1);
    end
    else if (waiting)
    begin
      if (count == 8'h00)
      begin
        waiting <= 1'b0;
        o_pulse <= 1'b1;
        count   <= 8'(WIDTH_CYC - 1);
      end
      else
      begin
        count <= count - 8'h01;
      end
    end
    else if (o_pulse)
    begin
      if (count != 8'h00)
        count <= count - 8'h01;
      else if (!i_hold)
        o_pulse <= 1'b0;  // least width met and host let go
    end
  end

endmodule

/* File: fah_host_port.sv */
// file adapter host port: extended register decode, read/write and
// control-store load control facing the shared-resources processor
// assumes all host pins are asynchronous to i_clk_sys and stable while a strobe is high
`timescale 1ns/1ns
`include "fah_params.svh"

module fah_host_port
  import fah_pkg::*;
(
  input  wire logic        i_clk_sys,             // system clock, 20 MHz
  input  wire logic        i_reset,               // sync reset, active high
  input  wire logic [4:0]  i_ext_reg_number,      // register number from host
  input  wire logic [15:0] i_ext_reg_out,         // word from host, bit 00 = [15]
  input  wire logic        i_ext_reg_write_strobe, // host store strobe
  input  wire logic        i_ext_reg_read_strobe, // host load strobe
  input  wire logic        i_io_master_clear,     // I/O master clear level
  input  wire logic        i_disc_source_select,  // disc source level
  input  wire logic        i_maintenance_indicator, // maintenance mode level
  input  wire logic        i_deadstart_initiate,  // start control-store load
  input  wire logic        i_cs_next_to_last,     // next-to-last load word moved
  input  wire logic        i_system_reset_press,  // system reset button level
  input  wire logic        i_load_error,          // status error during load
  input  fah_status_t      i_status,              // words from drive side
  output logic [15:0]      o_ext_reg_in,          // word to host
  output logic [15:0]      o_drive_select,        // selected drive word
  output fah_cmd_t         o_command,             // held command words
  output logic             o_command_start,       // pulse: command complete
  output logic [15:0]      o_write_data,          // last write data word
  output logic             o_write_valid,         // pulse: write data taken
  output logic             o_read_taken,          // pulse: read data consumed
  output logic             o_status_request,      // pulse: hw status asked
  output logic             o_attn_request,        // pulse: attention asked
  output logic             o_cyl_request,         // pulse: cylinder asked
  output logic [15:0]      o_data_byte_counter,   // words left in transfer
  output logic             o_rw_busy,             // read/write active
  output logic             o_load_active,         // control-store load running
  output logic             o_load_end_out,        // end-out to host
  output logic             o_deadstart_restart_request, // restart to host
  output logic             o_maint_mode,          // maintenance mode flag
  output logic             o_disc_source          // disc source flag
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int SW = 5 + 16 + 8;

  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;
  logic          wr_prev;
  logic          rd_prev;
  logic          doa_prev;

  // two flops on every host pin; only sync_b feeds logic
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {i_ext_reg_number, i_ext_reg_out, i_ext_reg_write_strobe,
                 i_ext_reg_read_strobe, i_io_master_clear, i_disc_source_select,
                 i_maintenance_indicator, i_deadstart_initiate, i_cs_next_to_last,
                 i_system_reset_press};
      sync_b <= sync_a;
    end
  end

  logic [4:0]  reg_num;
  logic [15:0] reg_word;
  logic        wr_lvl;
  logic        rd_lvl;
  logic        mclr;
  logic        doa_lvl;
  logic        ntl_lvl;
  logic        sysrst_lvl;

  assign reg_num    = sync_b[28:24];
  assign reg_word   = sync_b[23:8];
  assign wr_lvl     = sync_b[7];
  assign rd_lvl     = sync_b[6];
  assign mclr       = sync_b[5];
  assign doa_lvl    = sync_b[2];
  assign ntl_lvl    = sync_b[1];
  assign sysrst_lvl = sync_b[0];

  // edge history of the synchronised strobes
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      wr_prev  <= 1'b0;
      rd_prev  <= 1'b0;
      doa_prev <= 1'b0;
    end
    else
    begin
      wr_prev  <= wr_lvl;
      rd_prev  <= rd_lvl;
      doa_prev <= doa_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic in_range(input logic [4:0] num);
    in_range = (num >= `FAH_REG_LOW) && (num <= `FAH_REG_HIGH);
  endfunction

  logic wr_go;
  logic rd_go;
  logic clr;

  assign clr   = i_reset || mclr;
  assign wr_go = wr_lvl && !wr_prev && in_range(reg_num);
  assign rd_go = rd_lvl && !rd_prev && in_range(reg_num);

  ////////////////////////////////////////////////////////////////////////////
  // write side: selection, command words, request pulses

  fah_rw_state_t rw_state;
  logic [15:0]   attn_latch;
  logic [15:0]   cyl_latch;

  // selection and command words; other numbers leave all of this alone
  always_ff @(posedge i_clk_sys)
  begin
    if (clr)
    begin
      o_drive_select <= `FAH_DRIVE_DEFAULT;
      o_command      <= '0;
      o_write_data   <= `FAH_WORD_ZERO;
    end
    else if (wr_go)
    begin
      if (reg_num == `FAH_REG_DRIVE_SEL)
        o_drive_select <= reg_word;
      else if (reg_num == `FAH_REG_COMMAND)
        o_command.first <= reg_word;
      else if (reg_num == `FAH_REG_CMD_SECOND && rw_state == FAH_RW_SECOND)
        o_command.second <= reg_word;
      else if (reg_num == `FAH_REG_WRITE_DATA)
        o_write_data <= reg_word;
    end
  end

  // one-cycle request pulses toward the drive side
  always_ff @(posedge i_clk_sys)
  begin
    if (clr)
    begin
      o_status_request <= 1'b0;
      o_attn_request   <= 1'b0;
      o_cyl_request    <= 1'b0;
      o_write_valid    <= 1'b0;
    end
    else
    begin
      o_status_request <= wr_go && (reg_num == `FAH_REG_HW_STATUS);
      o_attn_request   <= wr_go && (reg_num == `FAH_REG_ATTN_STATUS);
      o_cyl_request    <= wr_go && (reg_num == `FAH_REG_CYL_STATUS);
      o_write_valid    <= wr_go && (reg_num == `FAH_REG_WRITE_DATA);
    end
  end

  // status snapshots taken when the host asks, so a later read is stable
  always_ff @(posedge i_clk_sys)
  begin
    if (clr)
    begin
      attn_latch <= `FAH_WORD_ZERO;
      cyl_latch  <= `FAH_WORD_ZERO;
    end
    else if (wr_go && reg_num == `FAH_REG_ATTN_STATUS)
      attn_latch <= i_status.attn_status;
    else if (wr_go && reg_num == `FAH_REG_CYL_STATUS)
      cyl_latch <= i_status.cyl_status;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side: one register toward the host

  // every word leaves through this single register
  always_ff @(posedge i_clk_sys)
  begin
    if (clr)
    begin
      o_ext_reg_in <= `FAH_WORD_ZERO;
      o_read_taken <= 1'b0;
    end
    else
    begin
      o_read_taken <= 1'b0;
      if (rd_go)
      begin
        if (reg_num == `FAH_REG_HW_STATUS)
          o_ext_reg_in <= i_status.hw_status;
        else if (reg_num == `FAH_REG_ATTN_STATUS)
          o_ext_reg_in <= attn_latch;
        else if (reg_num == `FAH_REG_CYL_STATUS)
          o_ext_reg_in <= cyl_latch;
        else
        begin
          o_ext_reg_in <= i_status.read_data;
          o_read_taken <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read/write control and byte counter

  logic data_move;

  assign data_move = (rw_state == FAH_RW_ACTIVE) &&
                     ((wr_go && reg_num == `FAH_REG_WRITE_DATA) ||
                      (rd_go && reg_num != `FAH_REG_HW_STATUS &&
                       reg_num != `FAH_REG_ATTN_STATUS && reg_num != `FAH_REG_CYL_STATUS));

  // a command waits for its second word before the transfer starts
  always_ff @(posedge i_clk_sys)
  begin
    if (clr)
    begin
      rw_state        <= FAH_RW_IDLE;
      o_command_start <= 1'b0;
    end
    else
    begin
      o_command_start <= 1'b0;
      case (rw_state)
        FAH_RW_IDLE:
          if (wr_go && reg_num == `FAH_REG_COMMAND)
            rw_state <= FAH_RW_SECOND;
        FAH_RW_SECOND:
          if (wr_go && reg_num == `FAH_REG_CMD_SECOND)
          begin
            rw_state        <= FAH_RW_ACTIVE;
            o_command_start <= 1'b1;
          end
        FAH_RW_ACTIVE:
          if (data_move && o_data_byte_counter == 16'h0001)
            rw_state <= FAH_RW_IDLE;
        default:
          rw_state <= FAH_RW_IDLE;
      endcase
    end
  end

  // counts words left; loads the preset only on reset or master clear and holds its count between transfers
  always_ff @(posedge i_clk_sys)
  begin
    if (clr)
      o_data_byte_counter <= `FAH_DBC_PRESET;
    else if (data_move)
      o_data_byte_counter <= o_data_byte_counter - 16'h0001;
  end

  // busy while a command waits for its second word or moves words
  always_ff @(posedge i_clk_sys)
  begin
    if (clr)
      o_rw_busy <= 1'b0;
    else
      o_rw_busy <= (rw_state != FAH_RW_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // control-store load control

  fah_ld_state_t ld_state;
  logic          end_trigger;
  logic          end_pulse;
  logic          ntl_prev;
  logic          err_sync_a;
  logic          err_sync_b;

  // load error pin gets its own synchroniser
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      err_sync_a <= 1'b0;
      err_sync_b <= 1'b0;
      ntl_prev   <= 1'b0;
    end
    else
    begin
      err_sync_a <= i_load_error;
      err_sync_b <= err_sync_a;
      ntl_prev   <= ntl_lvl;
    end
  end

  assign end_trigger = (ld_state == FAH_LD_RUN) &&
                       ((ntl_lvl && !ntl_prev) || sysrst_lvl);

  // load runs from deadstart initiate until end-out has been answered
  always_ff @(posedge i_clk_sys)
  begin
    if (clr)
      ld_state <= FAH_LD_IDLE;
    else
    begin
      case (ld_state)
        FAH_LD_IDLE:
          if (doa_lvl && !doa_prev)
            ld_state <= FAH_LD_RUN;
        FAH_LD_RUN:
          if (end_trigger)
            ld_state <= FAH_LD_END;
        FAH_LD_END:
          if (!end_pulse && !doa_lvl)
            ld_state <= FAH_LD_IDLE;
        default:
          ld_state <= FAH_LD_IDLE;
      endcase
    end
  end

  // end-out held for its width, and on until the host drops initiate
  fah_end_timer u_end_timer
  (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_clear   (mclr),
    .i_trigger (end_trigger),
    .i_hold    (doa_lvl),
    .o_pulse   (end_pulse)
  );

  // host-facing flags; restart follows the load error level only in FAH_LD_RUN, up to end_trigger, at least one 50 ns cycle to meet its least width
  always_ff @(posedge i_clk_sys)
  begin
    if (clr)
    begin
      o_load_active               <= 1'b0;
      o_load_end_out              <= 1'b0;
      o_deadstart_restart_request <= 1'b0;
      o_maint_mode                <= 1'b0;
      o_disc_source               <= 1'b0;
    end
    else
    begin
      o_load_active               <= (ld_state != FAH_LD_IDLE);
      o_load_end_out              <= end_pulse;
      o_deadstart_restart_request <= err_sync_b && (ld_state == FAH_LD_RUN);
      o_maint_mode                <= sync_b[3];
      o_disc_source               <= sync_b[4];
    end
  end

endmodule

/* File: fah_host_port_assertions.sv */
// pin-level checks on the file adapter host port
// assumes the host holds number and word steady while a strobe is high
`timescale 1ns/1ns

module fah_host_port_assertions
  import fah_pkg::*;
(
  input wire logic        i_clk_sys,               // clock
  input wire logic        i_reset,                 // reset
  input wire logic [4:0]  i_ext_reg_number,        // number
  input wire logic [15:0] i_ext_reg_out,           // host word
  input wire logic        i_ext_reg_write_strobe,  // store
  input wire logic        i_ext_reg_read_strobe,   // load
  input wire logic        i_io_master_clear,       // clear
  input wire logic        i_maintenance_indicator, // maint
  input wire logic        i_deadstart_initiate,    // initiate
  input wire logic        i_cs_next_to_last,       // last word
  input wire fah_status_t i_status,                // drive words
  input wire logic [15:0] o_ext_reg_in,            // to host
  input wire logic [15:0] o_drive_select,          // drive
  input wire fah_cmd_t    o_command,               // command
  input wire logic        o_write_valid,           // wr pulse
  input wire logic [15:0] o_write_data,            // wr word
  input wire logic [15:0] o_data_byte_counter,     // counter
  input wire logic        o_rw_busy,               // busy
  input wire logic        o_load_active,           // loading
  input wire logic        o_load_end_out,          // end-out
  input wire logic        o_maint_mode             // maint flag
);
  logic [2:0] up;   // cycles since reset, saturating
  logic [4:0] mch;  // recent clear history, spans its sync lag
  logic [7:0] hc;   // end-out high cycles

  ////////////////////////////////////////
  // helper counters
  always_ff @(posedge i_clk_sys)
    if (i_reset)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;

  always_ff @(posedge i_clk_sys)
    if (i_reset)
      mch <= 5'h00;
    else
      mch <= {mch[3:0], i_io_master_clear};

  always_ff @(posedge i_clk_sys)
    if (i_reset || !o_load_end_out)
      hc <= 8'h00;
    else if (hc != 8'hFF)
      hc <= hc + 8'h01;

  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  sequence s_wr(n);
    $rose(i_ext_reg_write_strobe) && i_ext_reg_number == n;
  endsequence
  sequence s_rd(n);
    $rose(i_ext_reg_read_strobe) && i_ext_reg_number == n;
  endsequence
  // writes below the range or with no write function
  sequence s_bad;
    $rose(i_ext_reg_write_strobe) && (i_ext_reg_number < 5'h10 || i_ext_reg_number == 5'h16
      || i_ext_reg_number >= 5'h18);
  endsequence
  sequence s_last;
    $rose(i_cs_next_to_last) && o_load_active && !o_load_end_out;
  endsequence

  a_clear_drive_zero: assert property (i_io_master_clear[*4] |=>
    o_drive_select == 16'h0000 && o_data_byte_counter == 16'hFA08 && !o_rw_busy && !o_load_active)
    else $error("master clear left state behind");
  a_drive_take: assert property (s_wr(5'h10) |-> ##[2:5] o_drive_select == i_ext_reg_out)
    else $error("drive select not taken");
  a_wdata_take: assert property (s_wr(5'h14) |-> ##[2:5] o_write_valid &&
    o_write_data == i_ext_reg_out)
    else $error("write data not taken");
  a_ignore_write: assert property (s_bad |-> ##1 ($stable(o_drive_select) &&
    $stable(o_command))[*6])
    else $error("ignored write changed state");
  a_hw_read: assert property (s_rd(5'h12) |-> ##[3:5] o_ext_reg_in == i_status.hw_status)
    else $error("hardware status not returned");
  a_maint_mirror: assert property ((up == 3'h7 && mch == 5'h00 &&
    $stable(i_maintenance_indicator))[*4] |-> o_maint_mode == i_maintenance_indicator)
    else $error("maintenance flag wrong");
  a_load_start: assert property ($rose(i_deadstart_initiate) && !o_load_active &&
    !o_load_end_out && mch == 5'h00 |-> ##[2:6] o_load_active)
    else $error("load did not start");
  a_end_delay: assert property (s_last |-> !o_load_end_out[*8] ##[12:32] $rose(o_load_end_out))
    else $error("end-out timing wrong");
  a_end_width: assert property ($fell(o_load_end_out) && mch == 5'h00 |-> hc >= 8'h3C)
    else $error("end-out too short");
  a_end_hold: assert property (o_load_end_out && i_deadstart_initiate &&
    $past(i_deadstart_initiate) && mch == 5'h00 |=> o_load_end_out)
    else $error("end-out dropped with initiate high");
endmodule

bind fah_host_port fah_host_port_assertions u_chk
(
  .i_clk_sys, .i_reset, .i_ext_reg_number, .i_ext_reg_out, .i_ext_reg_write_strobe,
  .i_ext_reg_read_strobe, .i_io_master_clear, .i_maintenance_indicator, .i_deadstart_initiate,
  .i_cs_next_to_last, .i_status, .o_ext_reg_in, .o_drive_select, .o_command, .o_write_valid,
  .o_write_data, .o_data_byte_counter, .o_rw_busy, .o_load_active, .o_load_end_out, .o_maint_mode
);

/* File: fah_host_model.sv */
// host processor model: register pins and the load handshake
// assumes the adapter answers within six clocks of a strobe
`timescale 1ns/1ns

module fah_host_model
(
  input  wire logic        i_clk_sys, // clock
  input  wire logic        i_end_out, // end-out
  input  wire logic [15:0] i_reg_in,  // word in
  output logic [4:0]       o_num,     // reg number
  output logic [15:0]      o_data,    // word out, bit 00 = [15]
  output logic             o_wr,      // store strobe
  output logic             o_rd,      // load strobe
  output logic             o_init,    // deadstart initiate
  output logic             o_disc     // disc source
);
  int hold_extra = 0;  // clocks the host lingers before dropping initiate

  ////////////////////////////////////////
  initial
  begin
    o_num = 5'h00;
    o_data = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_init = 1'b0;
    o_disc = 1'b0;
  end

  // one access: hold six clocks, then release for four
  task automatic acc(input logic w, input logic [4:0] n, input logic [15:0] d, output logic [15:0] q);
    @(negedge i_clk_sys);
    o_num = n;
    o_data = d;
    o_wr = w;
    o_rd = !w;
    repeat (6) @(negedge i_clk_sys);
    q = i_reg_in;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_data = ~d;      // released lines must not look held
    repeat (4) @(negedge i_clk_sys);
  endtask

  // disc source stays up for the whole load
  task automatic start_load;
    @(negedge i_clk_sys);
    o_disc = 1'b1;
    o_init = 1'b1;
  endtask

  // initiate is dropped once end-out is seen; a slow host lingers first
  always @(negedge i_clk_sys)
    if (i_end_out && o_init)
    begin
      repeat (hold_extra) @(negedge i_clk_sys);
      o_init = 1'b0;
    end
endmodule

/* File: tb_top.sv */
// self-checking bench for the file adapter host port
// host model drives register pins; drive side words come from here
`timescale 1ns/1ns

module tb_top
  import fah_pkg::*;
;
  logic        i_clk_sys = 1'b0;
  logic        i_reset = 1'b1;
  logic [4:0]  i_ext_reg_number;
  logic [15:0] i_ext_reg_out, o_ext_reg_in, o_drive_select, o_write_data, o_data_byte_counter, q;
  logic        i_ext_reg_write_strobe, i_ext_reg_read_strobe, i_deadstart_initiate, i_disc_source_select;
  logic        i_io_master_clear = 1'b0, i_maintenance_indicator = 1'b0, i_cs_next_to_last = 1'b0;
  logic        i_system_reset_press = 1'b0, i_load_error = 1'b0;  // raised in the second load
  fah_status_t i_status = {16'h1234, 16'h5A5A, 16'h0C3F, 16'hBEEF};
  fah_cmd_t    o_command;
  logic        o_command_start, o_write_valid, o_read_taken, o_status_request, o_attn_request;
  logic        o_cyl_request, o_rw_busy, o_load_active, o_load_end_out, o_deadstart_restart_request;
  logic        o_maint_mode, o_disc_source;
  int          n_mismatch = 0, compares = 0, k;
  int          n_sr = 0, n_ar = 0, n_cr = 0, n_cs = 0, n_rt = 0;  // pulse tallies

  ////////////////////////////////////////
  fah_host_port DUT
  (
    .i_clk_sys, .i_reset, .i_ext_reg_number, .i_ext_reg_out, .i_ext_reg_write_strobe,
    .i_ext_reg_read_strobe, .i_io_master_clear, .i_disc_source_select, .i_maintenance_indicator,
    .i_deadstart_initiate, .i_cs_next_to_last, .i_system_reset_press, .i_load_error, .i_status,
    .o_ext_reg_in, .o_drive_select, .o_command, .o_command_start, .o_write_data, .o_write_valid,
    .o_read_taken, .o_status_request, .o_attn_request, .o_cyl_request, .o_data_byte_counter,
    .o_rw_busy, .o_load_active, .o_load_end_out, .o_deadstart_restart_request, .o_maint_mode,
    .o_disc_source
  );

  fah_host_model HM
  (
    .i_clk_sys, .i_end_out(o_load_end_out), .i_reg_in(o_ext_reg_in), .o_num(i_ext_reg_number),
    .o_data(i_ext_reg_out), .o_wr(i_ext_reg_write_strobe), .o_rd(i_ext_reg_read_strobe),
    .o_init(i_deadstart_initiate), .o_disc(i_disc_source_select)
  );

  always #25 i_clk_sys = ~i_clk_sys;

  // one-cycle pulses tallied at the falling edge, where they are settled
  always @(negedge i_clk_sys)
  begin
    n_sr += o_status_request;
    n_ar += o_attn_request;
    n_cr += o_cyl_request;
    n_cs += o_command_start;
    n_rt += o_read_taken;
  end

  // compare and count; case inequality so unknowns fail
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [4:0] n, input logic [15:0] d);
    HM.acc(1'b1, n, d, q);
  endtask

  task automatic rd(input logic [4:0] n, input logic [15:0] e, input string nm);
    HM.acc(1'b0, n, 16'h0000, q);
    chk(nm, e, q);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // cut a hang short; the whole run needs well under a tenth of this
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    n_mismatch++;
    final_report();
  end

  ////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_reset = 1'b0;
    @(negedge i_clk_sys);
    chk("counter", 16'hFA08, o_data_byte_counter);
    chk("drive", 16'h0000, o_drive_select);
    wr(5'h10, 16'hA5C3);
    chk("drive", 16'hA5C3, o_drive_select);
    wr(5'h0F, 16'h1111);
    wr(5'h16, 16'h2222);
    wr(5'h1F, 16'h3333);
    wr(5'h15, 16'h4444);
    chk("drive", 16'hA5C3, o_drive_select);
    chk("command", 32'h0, o_command);
    // snapshots taken at the request, then the drive side moves on
    wr(5'h13, 16'h0000);
    wr(5'h17, 16'h0000);
    wr(5'h12, 16'h0000);
    i_status.attn_status = 16'h0000;
    i_status.cyl_status = 16'hFFFF;
    rd(5'h13, 16'h5A5A, "attention");
    rd(5'h17, 16'h0C3F, "cylinder");
    rd(5'h12, 16'h1234, "hw status");
    for (k = 0; k < 16; k++)
      if (k != 2 && k != 3 && k != 7)
        rd(5'(16 + k), 16'hBEEF, "read data");
    i_status.read_data = 16'h0000;
    rd(5'h0F, 16'hBEEF, "below range");
    // second first word replaces the first
    wr(5'h11, 16'h8001);
    wr(5'h11, 16'h8003);
    wr(5'h15, 16'h0042);
    chk("command", 32'h80030042, o_command);
    chk("busy", 1'b1, o_rw_busy);
    wr(5'h14, 16'hC0DE);
    chk("write data", 16'hC0DE, o_write_data);
    chk("counter", 16'hFA07, o_data_byte_counter);
    rd(5'h18, 16'h0000, "read data");
    chk("counter", 16'hFA06, o_data_byte_counter);
    i_io_master_clear = 1'b1;
    repeat (6) @(negedge i_clk_sys);
    i_io_master_clear = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    chk("drive", 16'h0000, o_drive_select);
    chk("counter", 16'hFA08, o_data_byte_counter);
    chk("busy", 1'b0, o_rw_busy);
    i_maintenance_indicator = 1'b1;
    repeat (5) @(negedge i_clk_sys);
    chk("maint", 1'b1, o_maint_mode);
    // next-to-last outside a load must be ignored
    i_cs_next_to_last = 1'b1;
    repeat (40) @(negedge i_clk_sys);
    i_cs_next_to_last = 1'b0;
    chk("end out", 1'b0, o_load_end_out);
    HM.start_load();
    repeat (6) @(negedge i_clk_sys);
    chk("load", 1'b1, o_load_active);
    chk("disc source", 1'b1, o_disc_source);
    i_cs_next_to_last = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    i_cs_next_to_last = 1'b0;
    for (k = 0; o_load_end_out !== 1'b1 && k < 60; k++)
      @(negedge i_clk_sys);
    chk("end rise", 1'b1, o_load_end_out);
    chk("end delay", 1'b1, k >= 16 && k <= 36);
    for (k = 0; o_load_end_out === 1'b1 && k < 200; k++)
      @(negedge i_clk_sys);
    chk("end width", 1'b1, k >= 60);
    repeat (4) @(negedge i_clk_sys);
    chk("load idle", 1'b0, o_load_active);
    // second load: error, reset press, and a host slow to drop initiate
    HM.hold_extra = 100;
    HM.start_load();
    repeat (6) @(negedge i_clk_sys);
    chk("load", 1'b1, o_load_active);
    i_load_error = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    chk("restart", 1'b1, o_deadstart_restart_request);
    i_load_error = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    chk("restart", 1'b0, o_deadstart_restart_request);
    i_system_reset_press = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    i_system_reset_press = 1'b0;
    for (k = 0; o_load_end_out !== 1'b1 && k < 60; k++)
      @(negedge i_clk_sys);
    chk("end delay", 1'b1, k >= 16 && k <= 36);
    for (k = 0; o_load_end_out === 1'b1 && k < 200; k++)
      @(negedge i_clk_sys);
    chk("end hold", 1'b1, k >= 100 && k <= 110);
    repeat (4) @(negedge i_clk_sys);
    chk("load idle", 1'b0, o_load_active);
    chk("status req", 32'h1, n_sr);
    chk("attn req", 32'h1, n_ar);
    chk("cyl req", 32'h1, n_cr);
    chk("cmd start", 32'h1, n_cs);
    chk("read taken", 32'hE, n_rt);
    final_report();
  end
endmodule
